// ==== hdl/bsp_consts.svh ====
// Purpose: constants of the boot loader and spi port
// Assumes: 100 MHz core clock
// Notes:   clock rates, counts, limits, command code, address and line level only
`ifndef BSP_CONSTS_SVH
`define BSP_CONSTS_SVH
`define BSP_CLK_HZ       100000000
`define BSP_PER_SCK_HZ   1000000
`define BSP_FLASH_HALF   4
`define BSP_READ_CMD     8'h03
`define BSP_START_ADDR   24'h000000
`define BSP_MAX_WR_BYTES 128
`define BSP_MAX_RD_BYTES 56
`define BSP_SEL_SETTLE   3
`define BSP_BOOT_LEN     1024
`define BSP_LINE_IDLE    1'b1
`endif

// ==== hdl/bsp_pkg.sv ====
// Purpose: types of the boot loader and spi port
// Assumes: nothing
// Notes:   states, byte carrier, command word
`default_nettype none
package bsp_pkg;
  // ----------------------------------------
  // state types
  // ----------------------------------------
  typedef enum logic [2:0] {
    BSP_B_STRAP = 3'h0,
    BSP_B_FCMD  = 3'h1,
    BSP_B_FDATA = 3'h2,
    BSP_B_SLAVE = 3'h3,
    BSP_B_DONE  = 3'h4
  } bsp_boot_st_t;
  typedef enum logic [1:0] {
    BSP_P_IDLE  = 2'h0,
    BSP_P_LOAD  = 2'h1,
    BSP_P_SHIFT = 2'h2,
    BSP_P_END   = 2'h3
  } bsp_per_st_t;
  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic       from_boot;
    logic [7:0] data;
  } bsp_byte_t;
  typedef struct packed {
    logic       read;
    logic [7:0] len;
  } bsp_cmd_t;
endpackage
`default_nettype wire

// ==== hdl/bsp_buf.sv ====
// Purpose: two-entry buffer with valid and ready
// Assumes: single clock, synchronous reset
// Notes:   head entry and its valid are flops
`timescale 1ns/1ns
`default_nettype none
module bsp_buf #(
  parameter int W = 9
) (
  input  wire logic         i_core_clk,
  input  wire logic         i_srst,
  input  wire logic         i_in_valid,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_in_ready,
  output logic              o_out_valid,
  output logic [W-1:0]      o_out_data,
  input  wire logic         i_out_ready
);
  if (W < 1) begin : g_bad_w
    $error("bsp_buf width must be positive");
  end
  logic [W-1:0] e0_q;
  logic [W-1:0] e1_q;
  logic         v0_q;
  logic         v1_q;
  wire          pop  = v0_q & i_out_ready;
  wire          push = i_in_valid & ~v1_q;
  assign o_in_ready  = ~v1_q;
  assign o_out_valid = v0_q;
  assign o_out_data  = e0_q;
  // ----------------------------------------
  // storage
  // ----------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      v0_q <= 1'b0;
      v1_q <= 1'b0;
      e0_q <= '0;
      e1_q <= '0;
    end else if (pop) begin
      if (v1_q) begin
        e0_q <= e1_q;
        v1_q <= 1'b0;
      end else if (push) begin
        e0_q <= i_in_data;
      end else begin
        v0_q <= 1'b0;
      end
    end else if (push) begin
      if (v0_q) begin
        e1_q <= i_in_data;
        v1_q <= 1'b1;
      end else begin
        e0_q <= i_in_data;
        v0_q <= 1'b1;
      end
    end
  end
endmodule // bsp_buf
`default_nettype wire

// ==== hdl/bsp_top.sv ====
// Purpose: boot image loader and spi port
// Assumes: 100 MHz core clock, pins sampled by two flops
// Notes:   boot bytes and peripheral read bytes leave on one stream
`include "bsp_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module bsp_top #(
  parameter int         BOOT_LEN   = `BSP_BOOT_LEN,
  parameter int         FLASH_HALF = `BSP_FLASH_HALF,
  parameter logic [7:0] READ_CMD   = `BSP_READ_CMD
) (
  input  wire logic             i_core_clk,
  input  wire logic             i_srst,
  input  wire logic [3:0]       i_flash_io,
  output logic [3:0]            o_flash_io,
  output logic [3:0]            o_flash_io_oe,
  output logic                  o_flash_clk,
  output logic                  o_flash_cs_n,
  output logic                  o_flash_ctl_oe,
  input  wire logic             i_spi_clk,
  input  wire logic             i_spi_cs_n,
  input  wire logic             i_spi_mosi,
  input  wire logic             i_spi_miso,
  output logic                  o_spi_clk,
  output logic                  o_spi_cs_n,
  output logic                  o_spi_mosi,
  output logic                  o_spi_oe,
  input  wire logic             i_cmd_valid,
  input  wire bsp_pkg::bsp_cmd_t i_cmd,
  output logic                  o_cmd_ready,
  output logic                  o_cmd_err,
  input  wire logic             i_wr_valid,
  input  wire logic [7:0]       i_wr_data,
  output logic                  o_wr_ready,
  output logic                  o_out_valid,
  output bsp_pkg::bsp_byte_t    o_out,
  input  wire logic             i_out_ready,
  output logic                  o_boot_slave,
  output logic                  o_boot_done,
  output logic                  o_boot_err
);
  localparam int PER_HALF = `BSP_CLK_HZ / (2 * `BSP_PER_SCK_HZ);
  if (BOOT_LEN < 1 || BOOT_LEN > 65536 || FLASH_HALF < 3 ||
      FLASH_HALF > 127 || PER_HALF < 3 || PER_HALF > 127) begin : g_bad
    $error("bsp_top parameters out of range");
  end
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [7:0] sync1_q;
  logic [7:0] sync2_q;
  logic [1:0] prev_q;
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      sync1_q <= 8'h20;
      sync2_q <= 8'h20;
      prev_q  <= 2'h2;
    end else begin
      sync1_q <= {i_spi_miso, i_spi_mosi, i_spi_cs_n, i_spi_clk, i_flash_io};
      sync2_q <= sync1_q;
      prev_q  <= sync2_q[5:4];
    end
  end
  wire [3:0] s_fio     = sync2_q[3:0];
  wire       s_clk     = sync2_q[4];
  wire       s_cs      = sync2_q[5];
  wire       s_mosi    = sync2_q[6];
  wire       s_miso    = sync2_q[7];
  wire       s_clk_rise = s_clk & ~prev_q[0];
  wire       s_cs_rise  = s_cs & ~prev_q[1];
  // ----------------------------------------
  // state
  // ----------------------------------------
  bsp_pkg::bsp_boot_st_t bst_q, bst_d;
  bsp_pkg::bsp_per_st_t  pst_q, pst_d;
  logic [6:0]  div_q, div_d;
  logic [4:0]  cnt_q, cnt_d;
  logic [31:0] sh_q, sh_d;
  logic [15:0] byte_q, byte_d;
  logic [3:0]  lo_q, lo_d;
  logic        rd_q, rd_d;
  logic        slave_q, slave_d;
  logic        err_q, err_d;
  logic        cerr_q, cerr_d;
  logic        fclk_q, fclk_d, fcs_q, fcs_d, foe_q, foe_d;
  logic [3:0]  fio_q, fio_d, fio_oe_q, fio_oe_d;
  logic        pclk_q, pclk_d, pcs_q, pcs_d, pmosi_q, pmosi_d;
  logic        poe_q, poe_d, done_q, crdy_q, wrdy_q;
  logic        buf_in_valid;
  logic        buf_in_ready;
  bsp_pkg::bsp_byte_t buf_in;
  // ----------------------------------------
  // divider
  // ----------------------------------------
  wire       in_done = (bst_q == bsp_pkg::BSP_B_DONE);
  wire [6:0] half    = in_done ? 7'(PER_HALF - 1) : 7'(FLASH_HALF - 1);
  wire       tick    = (div_q == 7'h00);
  assign div_d = tick ? half : div_q - 7'h01;
  wire [15:0] last_boot = 16'(BOOT_LEN - 1);
  wire [7:0]  rd_max    = 8'(`BSP_MAX_RD_BYTES);
  wire [7:0]  wr_max    = 8'(`BSP_MAX_WR_BYTES);
  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    bst_d = bst_q;
    pst_d = pst_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    byte_d = byte_q;
    lo_d = lo_q;
    rd_d = rd_q;
    slave_d = slave_q;
    err_d = err_q;
    cerr_d = 1'b0;
    fclk_d = fclk_q;
    fcs_d = fcs_q;
    foe_d = foe_q;
    fio_d = fio_q;
    fio_oe_d = fio_oe_q;
    pclk_d = pclk_q;
    pcs_d = pcs_q;
    pmosi_d = pmosi_q;
    poe_d = poe_q;
    buf_in_valid = 1'b0;
    buf_in = '0;
    unique case (bst_q)
      bsp_pkg::BSP_B_STRAP: begin
        cnt_d = cnt_q + 5'h01;
        if (cnt_q == 5'(`BSP_SEL_SETTLE - 1)) begin
          cnt_d = 5'h00;
          slave_d = s_fio[1];
          if (s_fio[1]) begin
            bst_d = bsp_pkg::BSP_B_SLAVE;
          end else begin
            bst_d = bsp_pkg::BSP_B_FCMD;
            foe_d = 1'b1;
            fcs_d = 1'b0;
            fio_oe_d = 4'hD;
            sh_d = {READ_CMD, `BSP_START_ADDR};
            fio_d = {`BSP_LINE_IDLE, `BSP_LINE_IDLE, 1'b0, READ_CMD[7]};
          end
        end
      end
      bsp_pkg::BSP_B_FCMD: begin
        if (tick) begin
          fclk_d = ~fclk_q;
          if (fclk_q) begin
            if (cnt_q == 5'h1F) begin
              bst_d = bsp_pkg::BSP_B_FDATA;
              fio_oe_d = 4'h0;
              cnt_d = 5'h00;
            end else begin
              sh_d = {sh_q[30:0], 1'b0};
              fio_d[0] = sh_q[30];
              cnt_d = cnt_q + 5'h01;
            end
          end
        end
      end
      bsp_pkg::BSP_B_FDATA: begin
        if (tick && !fclk_q && buf_in_ready) begin
          fclk_d = 1'b1;
        end else if (tick && fclk_q) begin
          fclk_d = 1'b0;
          cnt_d[0] = ~cnt_q[0];
          if (!cnt_q[0]) begin
            lo_d = s_fio;
          end else begin
            buf_in_valid = 1'b1;
            buf_in = '{from_boot: 1'b1, data: {s_fio, lo_q}};
            byte_d = byte_q + 16'h0001;
            if (byte_q == last_boot) begin
              bst_d = bsp_pkg::BSP_B_DONE;
              fcs_d = 1'b1;
            end
          end
        end
      end
      bsp_pkg::BSP_B_SLAVE: begin
        if (s_cs_rise) begin
          cnt_d = 5'h00;
          if (cnt_q[2:0] != 3'h0) begin
            err_d = 1'b1;
          end else if (byte_q != 16'h0000) begin
            bst_d = bsp_pkg::BSP_B_DONE;
          end
        end else if (!s_cs && s_clk_rise) begin
          sh_d[7:0] = {s_mosi, sh_q[7:1]};
          cnt_d = {2'b00, cnt_q[2:0] + 3'h1};
          if (cnt_q[2:0] == 3'h7) begin
            buf_in_valid = 1'b1;
            buf_in = '{from_boot: 1'b1, data: {s_mosi, sh_q[7:1]}};
            byte_d = byte_q + 16'h0001;
            err_d = err_q | ~buf_in_ready;
          end
        end
      end
      bsp_pkg::BSP_B_DONE: begin
        slave_d = slave_q;
        poe_d = 1'b1;
      end
      default: begin
        bst_d = bsp_pkg::BSP_B_STRAP;
      end
    endcase
    if (in_done && poe_q) begin
      unique case (pst_q)
        bsp_pkg::BSP_P_IDLE: begin
          if (i_cmd_valid && crdy_q) begin
            if (i_cmd.len == 8'h00 ||
                (i_cmd.read && i_cmd.len > rd_max) ||
                (!i_cmd.read && i_cmd.len > wr_max)) begin
              cerr_d = 1'b1;
            end else begin
              rd_d = i_cmd.read;
              byte_d = {8'h00, i_cmd.len};
              pcs_d = 1'b0;
              cnt_d = 5'h00;
              pst_d = i_cmd.read ? bsp_pkg::BSP_P_SHIFT : bsp_pkg::BSP_P_LOAD;
            end
          end
        end
        bsp_pkg::BSP_P_LOAD: begin
          // bytes from the host write port
          if (i_wr_valid) begin
            sh_d[7:0] = i_wr_data;
            pmosi_d = i_wr_data[7];
            pst_d = bsp_pkg::BSP_P_SHIFT;
          end
        end
        bsp_pkg::BSP_P_SHIFT: begin
          if (tick && !pclk_q && (!rd_q || buf_in_ready)) begin
            pclk_d = 1'b1;
          end else if (tick && pclk_q) begin
            pclk_d = 1'b0;
            sh_d[7:0] = {sh_q[6:0], rd_q ? s_miso : 1'b0};
            pmosi_d = sh_q[6];
            cnt_d = {2'b00, cnt_q[2:0] + 3'h1};
            if (cnt_q[2:0] == 3'h7) begin
              buf_in_valid = rd_q;
              buf_in = '{from_boot: 1'b0, data: {sh_q[6:0], s_miso}};
              byte_d = byte_q - 16'h0001;
              if (byte_q == 16'h0001) begin
                pst_d = bsp_pkg::BSP_P_END;
              end else if (!rd_q) begin
                pst_d = bsp_pkg::BSP_P_LOAD;
              end
            end
          end
        end
        bsp_pkg::BSP_P_END: begin
          if (tick) begin
            pcs_d = 1'b1;
            pmosi_d = 1'b0;
            pst_d = bsp_pkg::BSP_P_IDLE;
          end
        end
      endcase
    end
  end
  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      bst_q <= bsp_pkg::BSP_B_STRAP;
      pst_q <= bsp_pkg::BSP_P_IDLE;
      {div_q, cnt_q, sh_q, byte_q, lo_q} <= '0;
      {rd_q, slave_q, err_q, cerr_q, done_q, crdy_q, wrdy_q} <= '0;
      {fclk_q, foe_q, fio_q, fio_oe_q} <= '0;
      {pclk_q, pmosi_q, poe_q} <= '0;
      fcs_q <= 1'b1;
      pcs_q <= 1'b1;
    end else begin
      bst_q <= bst_d;
      pst_q <= pst_d;
      {div_q, cnt_q, sh_q, byte_q, lo_q} <= {div_d, cnt_d, sh_d, byte_d, lo_d};
      {rd_q, slave_q, err_q, cerr_q} <= {rd_d, slave_d, err_d, cerr_d};
      done_q <= (bst_d == bsp_pkg::BSP_B_DONE);
      crdy_q <= poe_d && (pst_d == bsp_pkg::BSP_P_IDLE);
      wrdy_q <= (pst_d == bsp_pkg::BSP_P_LOAD);
      {fclk_q, fcs_q, foe_q, fio_q, fio_oe_q} <=
        {fclk_d, fcs_d, foe_d, fio_d, fio_oe_d};
      {pclk_q, pcs_q, pmosi_q, poe_q} <= {pclk_d, pcs_d, pmosi_d, poe_d};
    end
  end
  // ----------------------------------------
  // output buffer
  // ----------------------------------------
  bsp_buf #(
    .W (9)
  ) bsp_buf_i (
    .i_core_clk  (i_core_clk),
    .i_srst      (i_srst),
    .i_in_valid  (buf_in_valid),
    .i_in_data   (buf_in),
    .o_in_ready  (buf_in_ready),
    .o_out_valid (o_out_valid),
    .o_out_data  (o_out),
    .i_out_ready (i_out_ready)
  );
  assign o_flash_io     = fio_q;
  assign o_flash_io_oe  = fio_oe_q;
  assign o_flash_clk    = fclk_q;
  assign o_flash_cs_n   = fcs_q;
  assign o_flash_ctl_oe = foe_q;
  assign o_spi_clk      = pclk_q;
  assign o_spi_cs_n     = pcs_q;
  assign o_spi_mosi     = pmosi_q;
  assign o_spi_oe       = poe_q;
  assign o_cmd_ready    = crdy_q;
  assign o_cmd_err      = cerr_q;
  assign o_wr_ready     = wrdy_q;
  assign o_boot_slave   = slave_q;
  assign o_boot_done    = done_q;
  assign o_boot_err     = err_q;
endmodule // bsp_top
`default_nettype wire

// ==== dv/bsp_top_assertions.sv ====
// Purpose: port checks of bsp_top
// Assumes: single clock, synchronous reset
// Notes:   bound to every bsp_top
`timescale 1ns/1ns
`default_nettype none
module bsp_top_assertions (
  input wire logic               i_core_clk,
  input wire logic               i_srst,
  input wire logic               i_cmd_valid,
  input wire bsp_pkg::bsp_cmd_t  i_cmd,
  input wire logic               i_out_ready,
  input wire logic [3:0]         o_flash_io,
  input wire logic [3:0]         o_flash_io_oe,
  input wire logic               o_flash_clk,
  input wire logic               o_flash_cs_n,
  input wire logic               o_flash_ctl_oe,
  input wire logic               o_spi_clk,
  input wire logic               o_spi_cs_n,
  input wire logic               o_spi_oe,
  input wire logic               o_cmd_ready,
  input wire logic               o_cmd_err,
  input wire logic               o_out_valid,
  input wire bsp_pkg::bsp_byte_t o_out,
  input wire logic               o_boot_slave,
  input wire logic               o_boot_done
);
  logic       prev_q;
  logic [6:0] run_q;
  logic [6:0] run_d;
  wire        bad_len;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_srst);
  // length limits per direction
  assign bad_len = i_cmd.len == 8'h00 || (!i_cmd.read && i_cmd.len > 8'h80)
    || (i_cmd.read && i_cmd.len > 8'h38);
  assign run_d = (o_spi_clk != prev_q) ? 7'h00 : run_q + 7'h01;
  always_ff @(posedge i_core_clk) begin
    prev_q <= i_srst ? 1'b0 : o_spi_clk;
    run_q  <= i_srst ? 7'h00 : run_d;
  end
  sequence s_bad_take;
    i_cmd_valid && o_cmd_ready && bad_len;
  endsequence
  sequence s_good_take;
    i_cmd_valid && o_cmd_ready && !bad_len;
  endsequence
  sequence s_refused;
    o_cmd_err && o_spi_cs_n ##1 !o_cmd_err && o_spi_cs_n;
  endsequence
  a_cmd_phase_pins: assert property (
    o_flash_io_oe != 4'h0 |-> !o_flash_cs_n && o_flash_io_oe == 4'hD
      && o_flash_io[3:1] == 3'h6) else $error("flash command pins wrong");
  a_flash_clk_idle: assert property (
    o_flash_cs_n |-> !o_flash_clk) else $error("flash clock not idle");
  a_slave_no_drive: assert property (
    o_boot_slave |-> !o_flash_ctl_oe && o_flash_io_oe == 4'h0)
    else $error("flash pins driven in slave boot");
  a_choice_holds: assert property (
    o_boot_done |=> $stable(o_boot_slave)) else $error("boot choice moved");
  a_master_after_boot: assert property (
    !o_boot_done |-> !o_spi_oe && !o_cmd_ready)
    else $error("peripheral port active before boot");
  a_refuse_pulse: assert property (
    s_bad_take |=> s_refused) else $error("bad request not refused");
  a_legal_select: assert property (
    s_good_take |=> !o_spi_cs_n && !o_cmd_err)
    else $error("legal request not started");
  a_sck_half_high: assert property (
    $fell(o_spi_clk) |-> run_q == 7'h31) else $error("spi high half wrong");
  a_out_word_holds: assert property (
    o_out_valid && !i_out_ready |=> o_out_valid && $stable(o_out))
    else $error("stalled word changed");
endmodule // bsp_top_assertions
bind bsp_top bsp_top_assertions bsp_top_assertions_i (.*);
`default_nettype wire

// ==== dv/bsp_flash_model.sv ====
// Purpose: quad flash partner holding the boot image
// Assumes: mode 0 clock, no dummy cycles
// Notes:   image byte k is 8'h3C plus k
`timescale 1ns/1ns
`default_nettype none
module bsp_flash_model (
  input  wire logic   i_clk,
  input  wire logic   i_cs_n,
  input  wire logic   i_io0,
  output logic [3:0]  o_io,
  output logic [31:0] o_hdr
);
  int         n;
  int         k;
  logic [7:0] b;
  initial begin
    o_io = 4'h0;
    n = 0;
  end
  always @(negedge i_cs_n) begin
    n = 0;
    k = 0;
  end
  always @(posedge i_clk) if (!i_cs_n && n < 32) begin
    o_hdr = {o_hdr[30:0], i_io0};
    n = n + 1;
  end
  always @(negedge i_clk) if (!i_cs_n && n == 32) begin
    b = 8'h3C + 8'(k / 2);
    o_io = k[0] ? b[7:4] : b[3:0];
    k = k + 1;
  end
  // released lines show the inverse
  always @(posedge i_cs_n) if (n == 32) o_io = ~o_io;
endmodule // bsp_flash_model
`default_nettype wire

// ==== dv/bsp_top_tb.sv ====
// Purpose: self-checking bench of bsp_top
// Assumes: 100 MHz core clock, 160 ns host clock
// Notes:   flash boot, peripheral transfers, then slave boot
`timescale 1ns/1ns
`default_nettype none
module bsp_top_tb;
  logic i_core_clk, i_srst, i_spi_clk, i_spi_cs_n, i_spi_mosi, strap;
  logic i_spi_miso, i_cmd_valid, i_wr_valid, i_out_ready, o_wr_ready;
  logic o_flash_clk, o_flash_cs_n, o_flash_ctl_oe, o_spi_clk, o_spi_cs_n;
  logic o_spi_mosi, o_spi_oe, o_cmd_ready, o_cmd_err, o_boot_err;
  logic o_out_valid, o_boot_slave, o_boot_done;
  logic [3:0]         i_flash_io, o_flash_io, o_flash_io_oe, fm_io;
  logic [7:0]         i_wr_data;
  logic [31:0]        fm_hdr;
  bsp_pkg::bsp_cmd_t  i_cmd;
  bsp_pkg::bsp_byte_t o_out, got;
  int                 bad_count, n_compared;
  assign i_flash_io = strap ? 4'h2
    : (o_flash_io & o_flash_io_oe) | (fm_io & ~o_flash_io_oe);
  bsp_top #(.BOOT_LEN(4)) bsp_top_i (.*);
  bsp_flash_model bsp_flash_model_i (
    .i_clk  (o_flash_clk),
    .i_cs_n (o_flash_cs_n),
    .i_io0  (o_flash_io[0]),
    .o_io   (fm_io),
    .o_hdr  (fm_hdr)
  );
  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end
  task automatic conclude();
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask
  task automatic get();
    int w;
    w = 0;
    while (o_out_valid !== 1'b1 && w < 20000) begin
      tick(1);
      w++;
    end
    got = o_out;
    tick(1);
  endtask
  task automatic issue(input bsp_pkg::bsp_cmd_t c, input logic err);
    int w;
    w = 0;
    while (o_cmd_ready !== 1'b1 && w < 2000) begin
      tick(1);
      w++;
    end
    i_cmd_valid <= 1'b1;
    i_cmd <= c;
    tick(1);
    i_cmd_valid <= 1'b0;
    chk(o_cmd_err, err);
    chk(o_spi_cs_n, err);
    tick(1);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_flash();
    int i;
    tick(300);
    chk(fm_hdr, {8'h03, 24'h000000});
    chk(o_flash_ctl_oe, 1'b1);
    i_out_ready <= 1'b1;
    for (i = 0; i < 4; i++) begin
      get();
      chk(got, {1'b1, 8'h3C + 8'(i)});
    end
    tick(20);
    chk({o_boot_done, o_boot_slave, o_spi_oe}, 3'h5);
  endtask
  task automatic t_write();
    logic [7:0] b;
    int         i;
    issue('{read: 1'b0, len: 8'h01}, 1'b0);
    chk(o_wr_ready, 1'b1);
    i_wr_data <= 8'hA5;
    i_wr_valid <= 1'b1;
    tick(1);
    i_wr_valid <= 1'b0;
    chk(o_wr_ready, 1'b0);
    for (i = 0; i < 8; i++) begin
      @(posedge o_spi_clk);
      b = {b[6:0], o_spi_mosi};
    end
    chk(b, 8'hA5);
  endtask
  task automatic t_read();
    logic [7:0] v;
    int         i;
    v = 8'h96;
    i_spi_miso <= v[7];
    issue('{read: 1'b1, len: 8'h01}, 1'b0);
    for (i = 6; i >= 0; i--) begin
      @(negedge o_spi_clk);
      i_spi_miso <= v[i];
    end
    @(negedge o_spi_clk);
    #1;
    i_spi_miso <= ~v[0];
    get();
    chk(got, {1'b0, 8'h96});
  endtask
  task automatic t_refuse();
    bsp_pkg::bsp_cmd_t c [3];
    int                i;
    c = '{'{1'b0, 8'h00}, '{1'b0, 8'h81}, '{1'b1, 8'h39}};
    for (i = 0; i < 3; i++) issue(c[i], 1'b1);
  endtask
  task automatic t_slave();
    logic [18:0] img;
    int          i;
    img = {16'hC35A, 3'h5};
    strap <= 1'b1;
    i_srst <= 1'b1;
    i_out_ready <= 1'b0;
    tick(6);
    i_srst <= 1'b0;
    tick(10);
    strap <= 1'b0;
    i_spi_cs_n <= 1'b0;
    for (i = 0; i < 19; i++) begin
      if (i == 3) begin
        i_spi_cs_n <= 1'b1;
        tick(16);
        i_spi_cs_n <= 1'b0;
      end
      i_spi_mosi <= img[i];
      tick(5);
      i_spi_clk <= 1'b1;
      tick(8);
      i_spi_clk <= 1'b0;
      tick(3);
    end
    i_spi_cs_n <= 1'b1;
    i_spi_mosi <= ~img[18];
    tick(10);
    i_out_ready <= 1'b1;
    get();
    chk(got, {1'b1, 8'h5A});
    get();
    chk(got, {1'b1, 8'hC3});
    tick(10);
    chk({o_boot_slave, o_boot_done, o_boot_err}, 3'h7);
  endtask
  initial begin
    bad_count = 0;
    n_compared = 0;
    {i_srst, strap, i_spi_cs_n} = 3'h5;
    {i_spi_clk, i_spi_mosi, i_spi_miso, i_cmd_valid} = 4'h0;
    {i_wr_valid, i_out_ready, i_wr_data} = 10'h000;
    i_cmd = '0;
    tick(6);
    i_srst <= 1'b0;
    t_flash();
    t_write();
    t_read();
    t_refuse();
    t_slave();
    conclude();
  end
  initial begin
    #500000;
    bad_count++;
    conclude();
  end
endmodule // bsp_top_tb
`default_nettype wire
